// >>> wake_power_ctrl.sv
// Wakeup/kickstart power-control sequencer of a battery-backed clock
`timescale 1ns/1ps

module wake_power_ctrl
   import wake_pkg::*;
#(
   parameter int unsigned TIMEOUT_CYCLES = POWER_ON_TIMEOUT_CYC
) (
   // Clock and reset
   input  wire logic         sys_clk_in,
   input  wire logic         reset_n_in,
   // Pins from outside the clock domain
   input  wire logic         wake_key_input_n_in,
   input  wire logic         system_supply_ok_in,
   input  wire logic         power_fail_ok_in,
   // Calendar alarm comparison result, same clock domain
   input  wire logic         alarm_match_in,
   // Other interrupt sources of the device, same clock domain
   input  wire logic         other_int_pending_in,
   // Software controls and flag writes
   input  wire wake_ctrl_t   ctrl_in,
   input  wire wake_write_t  write_in,
   // Open-drain power request pin
   output logic              power_on_request_n_out,
   output logic              power_on_request_n_oe_out,
   // Open-drain interrupt pin
   output logic              interrupt_n_out,
   output logic              interrupt_n_oe_out,
   // Status
   output wake_status_t      status_out
);

   // Elaboration-time check of the timeout
   if (TIMEOUT_CYCLES < 2 || TIMEOUT_CYCLES > 32'h00ff_ffff) begin : g_bad_timeout
      $error("TIMEOUT_CYCLES out of range");
   end

   localparam int unsigned TW = $clog2(TIMEOUT_CYCLES + 1);
   localparam logic [TW-1:0] TIMEOUT_LAST = TW'(TIMEOUT_CYCLES - 1);

   typedef struct packed {
      seq_state_t  seq;
      logic [TW-1:0] timer;
      logic        alarm_match_flag;
      logic        key_wake_flag;
      logic        power_down_request;
      logic        alarm_match_d;
      logic        req_drive;
      logic        irq_drive;
   } ctrl_state_t;

   ctrl_state_t state_reg;
   ctrl_state_t state_next;

   logic key_fall;
   logic supply_raw;
   logic supply_up;
   logic fail_ok;

   // Next flag value; a hardware set beats a software clear in the same cycle
   function automatic logic flag_next(input logic flag,
                                      input logic set,
                                      input logic clear);
      logic result;
      result = flag;
      if (clear) begin
         result = 1'b0;
      end
      if (set) begin
         result = 1'b1;
      end
      return result;
   endfunction

   // Key pin synchroniser and edge detector
   key_sync u_key_sync (
      .sys_clk_in          (sys_clk_in),
      .reset_n_in          (reset_n_in),
      .wake_key_input_n_in (wake_key_input_n_in),
      .key_fall_out        (key_fall)
   );

   // Supply above the larger of battery and fail level
   supply_sync u_supply_sync (
      .sys_clk_in (sys_clk_in),
      .reset_n_in (reset_n_in),
      .level_in   (supply_raw),
      .level_out  (supply_up)
   );

   // Supply above the fail level alone
   supply_sync u_fail_sync (
      .sys_clk_in (sys_clk_in),
      .reset_n_in (reset_n_in),
      .level_in   (power_fail_ok_in),
      .level_out  (fail_ok)
   );

   assign supply_raw = system_supply_ok_in;

   // Event qualification
   logic alarm_rise;
   logic alarm_event;
   logic key_event;
   logic wake_event;
   logic flag_int;

   always_comb begin
      alarm_rise  = alarm_match_in & ~state_reg.alarm_match_d & ctrl_in.update_transfer_enable;
      alarm_event = alarm_rise & ctrl_in.alarm_power_enable;
      key_event   = key_fall & ctrl_in.key_wake_int_enable;
      wake_event  = alarm_event | key_event;
      flag_int    = (state_reg.alarm_match_flag & ctrl_in.alarm_int_enable_alt)
                  | (state_reg.key_wake_flag & ctrl_in.key_wake_int_enable);
   end

   // Sequencer, flags and pin drive
   always_comb begin
      state_next               = state_reg;
      state_next.alarm_match_d = alarm_match_in;

      state_next.alarm_match_flag = flag_next(state_reg.alarm_match_flag, alarm_rise,
                                              write_in.clear_alarm_match_flag);
      state_next.key_wake_flag    = flag_next(state_reg.key_wake_flag, key_fall,
                                              write_in.clear_key_wake_flag);

      if (write_in.set_power_down_request) begin
         state_next.power_down_request = 1'b1;
      end else if (write_in.clear_power_down_request) begin
         state_next.power_down_request = 1'b0;
      end

      unique case (state_reg.seq)
         ST_OFF: begin
            state_next.req_drive = ctrl_in.powered_down_hold_select;
            if (wake_event) begin
               state_next.seq       = ST_WAIT;
               state_next.req_drive = 1'b1;
               state_next.timer     = '0;
            end else if (supply_up) begin
               // Supply applied by other means
               state_next.seq = ST_RELEASE;
               state_next.req_drive = 1'b0;
            end
         end
         ST_WAIT: begin
            state_next.req_drive = 1'b1;
            if (supply_up) begin
               state_next.seq                = ST_ON;
               state_next.power_down_request = 1'b0;
            end else if (state_reg.timer == TIMEOUT_LAST) begin
               state_next.seq       = ST_OFF;
               state_next.req_drive = ctrl_in.powered_down_hold_select;
            end else begin
               state_next.timer = state_reg.timer + TW'(1);
            end
         end
         ST_ON: begin
            state_next.req_drive = ~state_reg.power_down_request;
            if (state_reg.power_down_request) begin
               state_next.seq = ST_RELEASE;
            end
         end
         ST_RELEASE: begin
            state_next.req_drive = 1'b0;
            if (wake_event) begin
               state_next.seq                = ST_ON;
               state_next.req_drive          = 1'b1;
               state_next.power_down_request = 1'b0;
            end else if (!supply_up) begin
               state_next.seq       = ST_OFF;
               state_next.req_drive = ctrl_in.powered_down_hold_select;
            end
         end
         default: begin
            state_next.seq       = ST_OFF;
            state_next.req_drive = 1'b0;
         end
      endcase

      // released when flags and others clear
      state_next.irq_drive = 1'b0;
      if (fail_ok && (state_reg.seq == ST_ON || state_reg.seq == ST_RELEASE)) begin
         state_next.irq_drive = flag_int | other_int_pending_in;
      end
      if (state_reg.seq == ST_WAIT && !supply_up) begin
         state_next.irq_drive = 1'b0;
      end
   end

   // State register
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_reg <= '{seq:                ST_OFF,
                        timer:              '0,
                        alarm_match_flag:   RESET_FLAG,
                        key_wake_flag:      RESET_FLAG,
                        power_down_request: RESET_POWER_DOWN_REQUEST,
                        alarm_match_d:      1'b0,
                        req_drive:          1'b0,
                        irq_drive:          1'b0};
      end else begin
         state_reg <= state_next;
      end
   end

   // Open-drain pins: output value low, enable when pulling
   assign power_on_request_n_out    = 1'b0;
   assign power_on_request_n_oe_out = state_reg.req_drive;
   assign interrupt_n_out           = 1'b0;
   assign interrupt_n_oe_out        = state_reg.irq_drive;

   // Status view
   assign status_out = '{alarm_match_flag:   state_reg.alarm_match_flag,
                         key_wake_flag:      state_reg.key_wake_flag,
                         power_down_request: state_reg.power_down_request,
                         state:              state_reg.seq};

endmodule

// >>> wake_pkg.sv
// Shared constants and carrier types for the wakeup/kickstart power sequencer
package wake_pkg;

   // Power-on timeout in microseconds and the derived cycle count at 40 MHz
   localparam int unsigned POWER_ON_TIMEOUT_US  = 1000;
   localparam int unsigned CLK_RATE_MHZ         = 40;
   localparam int unsigned POWER_ON_TIMEOUT_CYC = POWER_ON_TIMEOUT_US * CLK_RATE_MHZ;

   // Reset values of the control state
   localparam logic RESET_POWER_DOWN_REQUEST = 1'b1;
   localparam logic RESET_FLAG               = 1'b0;

   // Sequencer states, one-hot
   typedef enum logic [3:0] {
      ST_OFF     = 4'b0001, // No supply, request released or held by hold select
      ST_WAIT    = 4'b0010, // Request driven, waiting for supply
      ST_ON      = 4'b0100, // Supply present, request held while not powering down
      ST_RELEASE = 4'b1000  // Request released, supply still present
   } seq_state_t;

   // Software controls presented as plain inputs
   typedef struct packed {
      logic alarm_power_enable;
      logic key_wake_int_enable;
      logic alarm_int_enable_alt;
      logic powered_down_hold_select;
      logic update_transfer_enable;
   } wake_ctrl_t;

   // Software flag writes: one-cycle strobes
   typedef struct packed {
      logic clear_alarm_match_flag;
      logic clear_key_wake_flag;
      logic set_power_down_request;
      logic clear_power_down_request;
   } wake_write_t;

   // Observable status
   typedef struct packed {
      logic       alarm_match_flag;
      logic       key_wake_flag;
      logic       power_down_request;
      seq_state_t state;
   } wake_status_t;

endpackage

// >>> key_sync.sv
// Three-stage synchroniser and falling-edge detector for the wake key pin
`timescale 1ns/1ps
module key_sync
   import wake_pkg::*;
(
   // Clock and reset
   input  wire logic sys_clk_in,
   input  wire logic reset_n_in,
   // Pin and result
   input  wire logic wake_key_input_n_in,
   output logic      key_fall_out
);

   typedef struct packed {
      logic [2:0] sync;
      logic       level;
      logic       fall;
   } key_state_t;

   key_state_t state_reg;
   key_state_t state_next;

   // Shift samples; a change counts once stages two and three agree
   always_comb begin
      state_next       = state_reg;
      state_next.sync  = {state_reg.sync[1:0], wake_key_input_n_in};
      state_next.fall  = 1'b0;
      if (state_reg.sync[1] == state_reg.sync[2]) begin
         state_next.level = state_reg.sync[2];
         state_next.fall  = state_reg.level & ~state_reg.sync[2];
      end
   end

   // Pin idles high, so reset to high to avoid a false edge
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_reg <= '{sync: 3'h7, level: 1'b1, fall: 1'b0};
      end else begin
         state_reg <= state_next;
      end
   end

   assign key_fall_out = state_reg.fall;

endmodule

// >>> supply_sync.sv
// Three-stage synchroniser for a supply comparator level
`timescale 1ns/1ps
module supply_sync (
   // Clock and reset
   input  wire logic sys_clk_in,
   input  wire logic reset_n_in,
   // Raw comparator level and filtered level
   input  wire logic level_in,
   output logic      level_out
);

   typedef struct packed {
      logic [2:0] sync;
      logic       level;
   } sup_state_t;

   sup_state_t state_reg;
   sup_state_t state_next;

   // Accept a new level only when stages two and three agree
   always_comb begin
      state_next      = state_reg;
      state_next.sync = {state_reg.sync[1:0], level_in};
      if (state_reg.sync[1] == state_reg.sync[2]) begin
         state_next.level = state_reg.sync[2];
      end
   end

   // Supply assumed absent at reset
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_reg <= '{sync: 3'h0, level: 1'b0};
      end else begin
         state_reg <= state_next;
      end
   end

   assign level_out = state_reg.level;

endmodule

// >>> wake_power_ctrl_properties.sv
// Port-level checker for the wake power sequencer
`timescale 1ns/1ps
module wake_power_ctrl_properties
   import wake_pkg::*;
#(
   parameter int unsigned TIMEOUT_CYCLES = POWER_ON_TIMEOUT_CYC
) (
   // Clock and reset
   input wire logic         sys_clk_in,
   input wire logic         reset_n_in,
   // Design inputs
   input wire logic         wake_key_input_n_in,
   input wire logic         system_supply_ok_in,
   input wire logic         power_fail_ok_in,
   input wire logic         alarm_match_in,
   input wire logic         other_int_pending_in,
   input wire wake_ctrl_t   ctrl_in,
   input wire wake_write_t  write_in,
   // Design outputs
   input wire logic         power_on_request_n_out,
   input wire logic         power_on_request_n_oe_out,
   input wire logic         interrupt_n_out,
   input wire logic         interrupt_n_oe_out,
   input wire wake_status_t status_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!reset_n_in);
   int unsigned wait_cnt_reg;
   // Cycles spent waiting for the supply
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in)
         wait_cnt_reg <= 0;
      else
         wait_cnt_reg <= (status_out.state == ST_WAIT) ? wait_cnt_reg + 1 : 0;
   end
   // Sequencer checks
   AST_ALARM_REQ: assert property ($rose(alarm_match_in) && ctrl_in.update_transfer_enable
      && ctrl_in.alarm_power_enable && status_out.state == ST_OFF
      |=> power_on_request_n_oe_out) else $error("alarm did not pull request");
   AST_KEY_FLAG: assert property ($fell(wake_key_input_n_in)
      |-> ##[3:7] status_out.key_wake_flag) else $error("key edge lost");
   AST_WAIT_BOUND: assert property (wait_cnt_reg <= TIMEOUT_CYCLES)
      else $error("supply wait too long");
   AST_ON_PDR: assert property (status_out.state == ST_ON && $past(status_out.state) == ST_WAIT
      |-> !status_out.power_down_request) else $error("power-down bit not cleared");
   AST_HOLD_ON: assert property (status_out.state == ST_ON && !status_out.power_down_request
      |-> power_on_request_n_oe_out) else $error("request dropped while on");
   AST_PDR_REL: assert property (write_in.set_power_down_request && status_out.state == ST_ON
      |-> ##[1:3] !power_on_request_n_oe_out) else $error("request not released");
   AST_FAIL_IRQ: assert property (!power_fail_ok_in [*6] |-> !interrupt_n_oe_out)
      else $error("interrupt driven without supply");
   AST_IRQ_REL: assert property ((!status_out.alarm_match_flag && !status_out.key_wake_flag
      && !other_int_pending_in) [*3] |-> !interrupt_n_oe_out) else $error("interrupt stuck");
   AST_HOLD_SEL: assert property (status_out.state == ST_OFF && $past(status_out.state) == ST_OFF
      && $stable(ctrl_in.powered_down_hold_select)
      |-> power_on_request_n_oe_out == ctrl_in.powered_down_hold_select)
      else $error("hold select ignored");
   // Open-drain pin values
   AST_REQ_LEVEL: assert property (power_on_request_n_out == 1'b0)
      else $error("request pin value not low");
   AST_IRQ_LEVEL: assert property (interrupt_n_out == 1'b0)
      else $error("interrupt pin value not low");
endmodule

bind wake_power_ctrl wake_power_ctrl_properties #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) chk_i (
   .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .wake_key_input_n_in(wake_key_input_n_in),
   .system_supply_ok_in(system_supply_ok_in), .power_fail_ok_in(power_fail_ok_in),
   .alarm_match_in(alarm_match_in), .other_int_pending_in(other_int_pending_in),
   .ctrl_in(ctrl_in), .write_in(write_in), .power_on_request_n_out(power_on_request_n_out),
   .power_on_request_n_oe_out(power_on_request_n_oe_out), .interrupt_n_out(interrupt_n_out),
   .interrupt_n_oe_out(interrupt_n_oe_out), .status_out(status_out));

// >>> supply_model.sv
// Behavioural system supply switched by the power request pin
`timescale 1ns/1ps
module supply_model #(
   parameter int unsigned RISE_CYCLES = 6
) (
   // Clock
   input  wire logic sys_clk_in,
   // Request pin and bench control
   input  wire logic request_oe_in,
   input  wire logic enable_in,
   input  wire logic external_in,
   // Comparator levels
   output logic      supply_ok_out,
   output logic      fail_ok_out
);
   int unsigned ramp_reg = 0;
   // Supply ramps while pulled on and enabled or fed from elsewhere, collapses otherwise
   always_ff @(posedge sys_clk_in) begin
      if (!((request_oe_in && enable_in) || external_in))
         ramp_reg <= 0;
      else if (ramp_reg < RISE_CYCLES)
         ramp_reg <= ramp_reg + 1;
   end
   // Both comparators trip at full ramp
   assign supply_ok_out = (ramp_reg == RISE_CYCLES);
   assign fail_ok_out   = (ramp_reg == RISE_CYCLES);
endmodule

// >>> wake_power_ctrl_tb_top.sv
// Self-checking bench for the wake power sequencer
`timescale 1ns/1ps
module wake_power_ctrl_tb_top;
   import wake_pkg::*;
   logic         sys_clk_in = 1'b0;
   logic         reset_n_in = 1'b0;
   logic         key_n      = 1'b1;
   logic         alarm      = 1'b0;
   logic         other_int  = 1'b0;
   logic         supply_en  = 1'b1;
   logic         supply_ext = 1'b0;
   logic         req_val;
   logic         irq_val;
   wake_ctrl_t   ctrl       = 5'h1d;
   wake_write_t  wr         = 4'h0;
   logic         supply_ok;
   logic         fail_ok;
   logic         req_oe;
   logic         irq_oe;
   wake_status_t st;
   int           num_errors = 0;
   int           n_compared = 0;
   // Clock
   always #12.5 sys_clk_in = ~sys_clk_in;
   // Design and supply
   wake_power_ctrl #(.TIMEOUT_CYCLES(20)) wake_power_ctrl_i (
      .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .wake_key_input_n_in(key_n),
      .system_supply_ok_in(supply_ok), .power_fail_ok_in(fail_ok), .alarm_match_in(alarm),
      .other_int_pending_in(other_int), .ctrl_in(ctrl), .write_in(wr),
      .power_on_request_n_out(req_val), .power_on_request_n_oe_out(req_oe),
      .interrupt_n_out(irq_val), .interrupt_n_oe_out(irq_oe), .status_out(st));
   supply_model supply_model_i (.sys_clk_in(sys_clk_in), .request_oe_in(req_oe),
      .enable_in(supply_en), .external_in(supply_ext), .supply_ok_out(supply_ok),
      .fail_ok_out(fail_ok));
   // Compare one bit
   task automatic check(string what, logic exp, logic got);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
      end
   endtask
   // Verdict
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge sys_clk_in);
      #1;
   endtask
   // One-cycle software strobe
   task automatic sw_write(wake_write_t w);
      @(posedge sys_clk_in) wr <= w;
      @(posedge sys_clk_in) wr <= 4'h0;
      #1;
   endtask
   // Alarm comparator pulse
   task automatic ring();
      @(posedge sys_clk_in) alarm <= 1'b1;
      @(posedge sys_clk_in) alarm <= 1'b0;
      #1;
   endtask
   // Key held low nine cycles
   task automatic press();
      @(posedge sys_clk_in) key_n <= 1'b0;
      tick(8);
      @(posedge sys_clk_in) key_n <= 1'b1;
      #1;
   endtask
   // Bounded wait for a state
   task automatic wait_state(seq_state_t s);
      for (int i = 0; i < 60 && st.state !== s; i++)
         tick(1);
      check("state", 1'b1, st.state === s);
      if (st.state !== s)
         conclude();
   endtask
   // Test sequence
   initial begin
      repeat (2) @(posedge sys_clk_in);
      reset_n_in <= 1'b1;
      tick(2);
      check("req_oe", 1'b0, req_oe);
      check("pdr", 1'b1, st.power_down_request);
      check("req_val", 1'b0, req_val);
      check("irq_val", 1'b0, irq_val);
      $display("test reset done");
      ring();
      check("req_oe", 1'b1, req_oe);
      check("alarm_flag", 1'b1, st.alarm_match_flag);
      wait_state(ST_ON);
      check("req_oe", 1'b1, req_oe);
      check("pdr", 1'b0, st.power_down_request);
      tick(2);
      check("irq_oe", 1'b1, irq_oe);
      sw_write(4'hc);
      tick(3);
      check("irq_oe", 1'b0, irq_oe);
      @(posedge sys_clk_in) other_int <= 1'b1;
      tick(3);
      check("irq_oe", 1'b1, irq_oe);
      @(posedge sys_clk_in) other_int <= 1'b0;
      press();
      tick(2);
      check("key_flag", 1'b1, st.key_wake_flag);
      check("irq_oe", 1'b1, irq_oe);
      check("req_oe", 1'b1, req_oe);
      sw_write(4'hc);
      $display("test alarm_wake done");
      @(posedge sys_clk_in) ctrl <= 5'h1c;
      ring();
      tick(1);
      check("alarm_flag", 1'b0, st.alarm_match_flag);
      @(posedge sys_clk_in) ctrl <= 5'h11;
      ring();
      press();
      tick(2);
      check("alarm_flag", 1'b1, st.alarm_match_flag);
      check("irq_oe", 1'b0, irq_oe);
      sw_write(4'hc);
      @(posedge sys_clk_in) ctrl <= 5'h1d;
      other_int <= 1'b1;
      sw_write(4'h2);
      tick(3);
      check("req_oe", 1'b0, req_oe);
      check("irq_oe", 1'b1, irq_oe);
      wait_state(ST_OFF);
      tick(6);
      check("irq_oe", 1'b0, irq_oe);
      $display("test power_down done");
      @(posedge sys_clk_in) ctrl <= 5'h01;
      other_int <= 1'b0;
      ring();
      press();
      tick(2);
      check("req_oe", 1'b0, req_oe);
      check("key_flag", 1'b1, st.key_wake_flag);
      sw_write(4'hc);
      @(posedge sys_clk_in);
      ctrl <= 5'h1d;
      supply_en <= 1'b0;
      press();
      check("req_oe", 1'b1, req_oe);
      wait_state(ST_OFF);
      check("req_oe", 1'b0, req_oe);
      check("irq_oe", 1'b0, irq_oe);
      check("key_flag", 1'b1, st.key_wake_flag);
      @(posedge sys_clk_in) supply_en <= 1'b1;
      ring();
      wait_state(ST_ON);
      check("key_flag", 1'b1, st.key_wake_flag);
      sw_write(4'hc);
      $display("test failed_attempt done");
      @(posedge sys_clk_in) ctrl <= 5'h1f;
      sw_write(4'h2);
      @(posedge sys_clk_in) supply_en <= 1'b0;
      wait_state(ST_OFF);
      tick(2);
      check("req_oe", 1'b1, req_oe);
      check("irq_oe", 1'b0, irq_oe);
      $display("test hold_select done");
      @(posedge sys_clk_in) supply_ext <= 1'b1;
      wait_state(ST_RELEASE);
      check("req_oe", 1'b0, req_oe);
      press();
      tick(2);
      check("req_oe", 1'b1, req_oe);
      check("pdr", 1'b0, st.power_down_request);
      check("irq_oe", 1'b1, irq_oe);
      $display("test other_supply done");
      conclude();
   end
endmodule
